// ===== hw/thmal_signalling.sv
// thermal alarm pin and power state indicator logic
`timescale 1ns/1ps
// ==========================================
// Overview of operation
// - sensor at max safe temperature drives alarm active and enables control circuit if allowed
// - in bidirectional mode an external alarm activates the control circuit if allowed
// - external activation lasts while the outside party holds the alarm, starting and ending three clocks after the pin level changes
// - after reset the pin is output only and outside levels are ignored
// - pin accepts external assertions only once firmware sets the bidirectional enable
module thmal_signalling (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic sensor_hot,
    input wire logic control_enable,
    input wire logic bidir_enable_set,
    input wire logic bidir_enable_clear,
    input wire thmal_pkg::thmal_pstate_type power_state,
    input wire logic thermal_alarm_n_in,
    output logic thermal_alarm_n_out,
    output logic thermal_alarm_n_oe,
    output logic thermal_control_circuit,
    output logic power_state_indicator_n,
    output logic bidir_enabled
);
    // ==========================================
    // state
    logic bidir_en;
    logic next_bidir_en;
    logic sync_meta;
    logic sync_ext;
    logic next_sync_meta;
    logic next_sync_ext;
    logic drive_alarm;
    logic next_drive_alarm;
    logic drive_dly1;
    logic drive_dly2;
    logic next_drive_dly1;
    logic next_drive_dly2;
    logic control_on;
    logic next_control_on;
    logic indicator_n;
    logic next_indicator_n;
    thmal_pkg::thmal_src_type src;
    thmal_pkg::thmal_src_type next_src;
    logic own_echo;
    logic ext_req;

    // power state decode, true for states with the indicator asserted
    function automatic logic indicator_state(input thmal_pkg::thmal_pstate_type st);
        case (st)
            thmal_pkg::THMAL_PST_HIGH_FREQ,
            thmal_pkg::THMAL_PST_MID_FREQ,
            thmal_pkg::THMAL_PST_LOW_FREQ,
            thmal_pkg::THMAL_PST_DEEP_SLEEP,
            thmal_pkg::THMAL_PST_DEEPER_SLEEP: indicator_state = 1'b1;
            default: indicator_state = 1'b0;
        endcase
    endfunction

    // ==========================================
    // bidirectional mode enable
    // firmware enable, set wins over clear, off after reset
    always_comb begin
        next_bidir_en = bidir_en;
        if (bidir_enable_clear) begin
            next_bidir_en = 1'b0;
        end
        if (bidir_enable_set) begin
            next_bidir_en = 1'b1;
        end
    end

    // mode register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bidir_en <= thmal_pkg::BIDIR_EN_RESET;
        end else begin
            bidir_en <= next_bidir_en;
        end
    end

    // ==========================================
    // external level synchroniser
    // the line also carries our own drive, so that drive is delayed alongside
    // the two stages; otherwise its echo would pass for an outside alarm
    always_comb begin
        next_sync_meta = ~thermal_alarm_n_in;
        next_sync_ext = sync_meta;
        next_drive_dly1 = drive_alarm;
        next_drive_dly2 = drive_dly1;
    end

    // synchroniser and echo delay registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_meta <= thmal_pkg::SYNC_RESET;
            sync_ext <= thmal_pkg::SYNC_RESET;
            drive_dly1 <= thmal_pkg::DRIVE_RESET;
            drive_dly2 <= thmal_pkg::DRIVE_RESET;
        end else begin
            sync_meta <= next_sync_meta;
            sync_ext <= next_sync_ext;
            drive_dly1 <= next_drive_dly1;
            drive_dly2 <= next_drive_dly2;
        end
    end

    // own drive still visible somewhere in the synchroniser
    assign own_echo = drive_alarm || drive_dly1 || drive_dly2;
    // external request only in bidirectional mode, own echo masked
    // an outside pull that overlaps our own drive cannot be told apart
    assign ext_req = bidir_en && sync_ext && !own_echo;

    // ==========================================
    // alarm pin drive
    // pin drive follows the sensor
    always_comb begin
        next_drive_alarm = sensor_hot;
    end

    // pin drive register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            drive_alarm <= thmal_pkg::DRIVE_RESET;
        end else begin
            drive_alarm <= next_drive_alarm;
        end
    end

    // open-drain style pin: drive low only when hot
    assign thermal_alarm_n_out = drive_alarm ? 1'b0 : thmal_pkg::ALARM_N_IDLE;
    assign thermal_alarm_n_oe = drive_alarm;

    // ==========================================
    // thermal control activation
    // sensor has priority, external request acts only while held
    always_comb begin
        next_control_on = 1'b0;
        next_src = thmal_pkg::THMAL_SRC_IDLE;
        if (control_enable && sensor_hot) begin
            next_control_on = 1'b1;
            next_src = thmal_pkg::THMAL_SRC_SENSOR;
        end else if (control_enable && ext_req) begin
            next_control_on = 1'b1;
            next_src = thmal_pkg::THMAL_SRC_EXTERNAL;
        end
    end

    // activation registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            control_on <= thmal_pkg::CONTROL_RESET;
            src <= thmal_pkg::THMAL_SRC_IDLE;
        end else begin
            control_on <= next_control_on;
            src <= next_src;
        end
    end

    // activation and mode outputs
    assign thermal_control_circuit = control_on;
    assign bidir_enabled = bidir_en;

    // ==========================================
    // power state indicator
    always_comb begin
        if (indicator_state(power_state)) begin
            next_indicator_n = thmal_pkg::INDICATOR_N_ACTIVE;
        end else begin
            next_indicator_n = thmal_pkg::INDICATOR_N_INACTIVE;
        end
    end

    // indicator register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            indicator_n <= thmal_pkg::INDICATOR_N_INACTIVE;
        end else begin
            indicator_n <= next_indicator_n;
        end
    end

    // indicator output
    assign power_state_indicator_n = indicator_n;

    // ==========================================
    // checks
    // external request held while the device itself is quiet
    sequence ext_held_s;
        bidir_en && sync_ext && !own_echo && control_enable && !sensor_hot;
    endsequence

    // device stops driving while the line is otherwise released
    sequence own_release_s;
        $fell(drive_alarm) && thermal_alarm_n_in && !sensor_hot ##1 thermal_alarm_n_in && !sensor_hot;
    endsequence

    // outside pull seen on two samples
    sequence pin_pulled_s;
        $fell(thermal_alarm_n_in) ##1 !thermal_alarm_n_in;
    endsequence

    sensor_drives_pin_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sensor_hot |=> !thermal_alarm_n_out && thermal_alarm_n_oe)
        else $error("alarm pin not driven after sensor hot");
    alarm_release_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !sensor_hot |=> thermal_alarm_n_out && !thermal_alarm_n_oe)
        else $error("alarm pin still driven after sensor cooled");
    sensor_control_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sensor_hot && control_enable |=> thermal_control_circuit)
        else $error("control circuit not activated by sensor");
    sensor_priority_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sensor_hot && control_enable |=> src == thmal_pkg::THMAL_SRC_SENSOR)
        else $error("sensor activation not given priority");
    ext_control_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ext_held_s |=> thermal_control_circuit && src == thmal_pkg::THMAL_SRC_EXTERNAL)
        else $error("external alarm did not activate control circuit");
    control_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !control_enable |=> !thermal_control_circuit)
        else $error("control circuit active while disabled");
    echo_masked_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        own_release_s |-> !thermal_control_circuit ##1 !thermal_control_circuit)
        else $error("own alarm drive taken as external request");
    ext_release_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !sensor_hot ##1 !sensor_hot && $fell(sync_ext) |=> !thermal_control_circuit)
        else $error("control circuit stayed on after release");
    output_only_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !bidir_en && !sensor_hot |=> !thermal_control_circuit)
        else $error("external level acted while output only");
    bidir_enable_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        bidir_enable_set |=> bidir_en)
        else $error("bidirectional enable not taken");
    clear_enable_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        bidir_enable_clear && !bidir_enable_set |=> !bidir_en)
        else $error("bidirectional enable not cleared");
    indicator_state_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        power_state == thmal_pkg::THMAL_PST_DEEPER_SLEEP |=> !power_state_indicator_n)
        else $error("indicator not asserted in deeper sleep");
    indicator_off_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        power_state == thmal_pkg::THMAL_PST_TURBO |=> power_state_indicator_n)
        else $error("indicator asserted above the normal range");
    sync_delay_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        pin_pulled_s |=> sync_ext)
        else $error("synchroniser delay too long");
    sync_depth_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(thermal_alarm_n_in) |=> !sync_ext)
        else $error("synchroniser delay too short");
endmodule

// ===== hw/thmal_pkg.sv
// package of constants and types for the thermal alarm signalling block
package thmal_pkg;
    // ==========================================
    // synchroniser and reset values
    localparam int SYNC_STAGES = 2;
    localparam logic BIDIR_EN_RESET = 1'b0;
    localparam logic ALARM_N_IDLE = 1'b1;
    localparam logic INDICATOR_N_ACTIVE = 1'b0;
    localparam logic INDICATOR_N_INACTIVE = 1'b1;
    localparam logic SYNC_RESET = 1'b0;
    localparam logic DRIVE_RESET = 1'b0;
    localparam logic CONTROL_RESET = 1'b0;

    // ==========================================
    // processor power states seen by the indicator
    typedef enum logic [2:0] {
        THMAL_PST_HIGH_FREQ,
        THMAL_PST_MID_FREQ,
        THMAL_PST_LOW_FREQ,
        THMAL_PST_DEEP_SLEEP,
        THMAL_PST_DEEPER_SLEEP,
        THMAL_PST_TURBO,
        THMAL_PST_OTHER
    } thmal_pstate_type;

    // ==========================================
    // activation source of the thermal control circuit
    typedef enum logic [1:0] {
        THMAL_SRC_IDLE,
        THMAL_SRC_SENSOR,
        THMAL_SRC_EXTERNAL
    } thmal_src_type;
endpackage

// ===== tb/thmal_platform.sv
// platform logic model sharing the alarm line
`timescale 1ns/1ps
module thmal_platform (
    input wire logic pull_low,
    input wire logic dev_out,
    input wire logic dev_oe,
    output logic line_level
);
    // ==========================================
    // open drain line with pull-up, low while any side pulls
    assign line_level = ~(pull_low | (dev_oe & ~dev_out));
endmodule

// ===== tb/tb_top.sv
// testbench for the thermal alarm signalling block
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 0, arst_n = 0, hot = 0, control_en = 1, set_en = 0, clr_en = 0, pull = 0;
    thmal_pkg::thmal_pstate_type ps = thmal_pkg::THMAL_PST_TURBO;
    logic pin, out, oe, control_on, ind_n, bidir;
    int fail_count = 0, total_checks = 0, cycles = 0;
    // ==========================================
    // clock, design and platform model
    always #12.5 sys_clk = ~sys_clk;
    thmal_signalling dut (.sys_clk(sys_clk), .arst_n(arst_n), .sensor_hot(hot), .control_enable(control_en),
        .bidir_enable_set(set_en), .bidir_enable_clear(clr_en), .power_state(ps), .thermal_alarm_n_in(pin),
        .thermal_alarm_n_out(out), .thermal_alarm_n_oe(oe), .thermal_control_circuit(control_on),
        .power_state_indicator_n(ind_n), .bidir_enabled(bidir));
    thmal_platform plat (.pull_low(pull), .dev_out(out), .dev_oe(oe), .line_level(pin));
    // compare one bit and count
    task chk(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // outside pulls ignored while output only
    task test_output_only;
        pull = 1;
        step(5);
        chk(control_on, 1'b0);
        chk(bidir, 1'b0);
        pull = 0;
        step(4);
    endtask
    // sensor drives pin and circuit
    task test_sensor;
        hot = 1;
        step(1);
        chk(control_on, 1'b1);
        chk(oe & ~out, 1'b1);
        control_en = 0;
        step(1);
        chk(control_on, 1'b0);
        chk(oe & ~out, 1'b1);
        hot = 0;
        control_en = 1;
        step(1);
        chk(oe, 1'b0);
        chk(out, 1'b1);
    endtask
    // external alarm through the synchroniser
    task test_external;
        set_en = 1;
        step(1);
        set_en = 0;
        chk(bidir, 1'b1);
        pull = 1;
        step(2);
        chk(control_on, 1'b0);
        step(1);
        chk(control_on, 1'b1);
        step(6);
        chk(control_on, 1'b1);
        pull = 0;
        step(2);
        chk(control_on, 1'b1);
        step(1);
        chk(control_on, 1'b0);
        control_en = 0;
        pull = 1;
        step(4);
        chk(control_on, 1'b0);
        pull = 0;
        step(3);
        control_en = 1;
        clr_en = 1;
        step(1);
        clr_en = 0;
        chk(bidir, 1'b0);
        pull = 1;
        step(4);
        chk(control_on, 1'b0);
        pull = 0;
        step(3);
    endtask
    // own drive must not come back as an external request
    task test_echo;
        set_en = 1;
        step(1);
        set_en = 0;
        chk(bidir, 1'b1);
        hot = 1;
        step(2);
        chk(control_on, 1'b1);
        hot = 0;
        repeat (4) begin
            step(1);
            chk(control_on, 1'b0);
        end
    endtask
    // a later reset returns the pin to output only
    task test_reset_again;
        arst_n = 0;
        step(2);
        chk(bidir, 1'b0);
        chk(oe, 1'b0);
        chk(ind_n, thmal_pkg::INDICATOR_N_INACTIVE);
        arst_n = 1;
        step(2);
        pull = 1;
        step(5);
        chk(control_on, 1'b0);
        chk(bidir, 1'b0);
        pull = 0;
        step(3);
    endtask
    // indicator over every power state
    task test_indicator;
        for (int i = 0; i < 7; i++) begin
            ps = thmal_pkg::thmal_pstate_type'(3'(i));
            step(1);
            chk(ind_n, (i < 5) ? thmal_pkg::INDICATOR_N_ACTIVE : thmal_pkg::INDICATOR_N_INACTIVE);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            report_and_stop;
        end
    end
    // ==========================================
    // main sequence
    initial begin
        step(12);
        arst_n = 1;
        step(2);
        test_output_only;
        test_sensor;
        test_external;
        test_echo;
        test_reset_again;
        test_indicator;
        report_and_stop;
    end
endmodule
